//--- tcd_params.svh
// Constants for the tracking converter digital port: offsets, resets, timing.
// Assumes a 250 MHz aclk; every cycle count below is derived from that rate.
`ifndef TCD_PARAMS_SVH
`define TCD_PARAMS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define TCD_OFF_CTRL 4'h0
`define TCD_OFF_STATUS 4'h4
`define TCD_OFF_ANGLE 4'h8
`define TCD_OFF_OUTWORD 4'hC

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define TCD_CTRL_TRACK_BIT 0
`define TCD_CTRL_FORCE_BIT 1
`define TCD_CTRL_RESET 2'h1
`define TCD_RES_RESET 2'h3
`define TCD_FAULT_LSBS 17'h00041

// ----------------------------------------
// Timing
// ----------------------------------------
`define TCD_CLK_MHZ 250
`define TCD_STROBE_NS 400
`define TCD_DELAY_NS 50
`define TCD_STROBE_CYC (((`TCD_STROBE_NS * `TCD_CLK_MHZ) + 999) / 1000)
`define TCD_DELAY_CYC (((`TCD_DELAY_NS * `TCD_CLK_MHZ) + 999) / 1000)

`endif

//--- tcd_pkg.sv
// Types shared by the tracking converter digital port.
// Assumes the constants header is included where numbers are needed.
package tcd_pkg;

	// ----------------------------------------
	// Resolution codes and strobe sequencer
	// ----------------------------------------
	typedef enum logic [1:0] {
		TCD_RES_10,
		TCD_RES_12,
		TCD_RES_14,
		TCD_RES_16
	} tcd_res_t;

	typedef enum logic [0:0] {
		TCD_IDLE,
		TCD_PULSE
	} tcd_state_t;

	// Fault sources from the analog side
	typedef struct packed {
		logic over_velocity;
		logic null_fail;
		logic input_signal_lost;
		logic reference_lost;
	} tcd_fault_t;

	// One tri-state byte lane
	typedef struct packed {
		logic [7:0] data;
		logic oe;
	} tcd_lane_t;

endpackage

//--- tcd_sync.sv
// Three-stage synchroniser for pin inputs.
// Assumes inputs are asynchronous to aclk; output moves only when stages 2 and 3 agree.
`timescale 1ns/1ps
module tcd_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// Stage 1 is read only by stage 2 to keep metastability contained
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
		end else if (ce) begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Accept a bit only once two stages agree on it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= INIT;
		end else if (ce) begin
			for (int i = 0; i < W; i++) begin
				if (s2[i] == s3[i]) begin
					q[i] <= s3[i];
				end
			end
		end
	end
endmodule // tcd_sync

//--- tcd_top.sv
// Digital port of a tracking angle converter: up/down angle counter, update
// strobe, resolution select, fault flag, hold latch and two tri-state bytes.
// Assumes VCO count pulses and all control pins are asynchronous to aclk;
// the tracking error word comes from logic on aclk. Software uses AXI4-Lite.
`timescale 1ns/1ps
`include "tcd_params.svh"

module tcd_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic count_up,
	input wire logic count_down,
	input wire logic signed [16:0] tracking_error,
	input wire tcd_pkg::tcd_fault_t fault_pins,
	input wire logic res_sel_hi,
	input wire logic res_sel_lo,
	input wire logic hold_output_n,
	input wire logic upper_byte_enable_n,
	input wire logic lower_byte_enable_n,
	output logic update_strobe,
	output logic fault_n,
	output tcd_pkg::tcd_lane_t upper_lane,
	output tcd_pkg::tcd_lane_t lower_lane
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	localparam logic [7:0] STROBE_CYC = 8'(`TCD_STROBE_CYC);
	localparam logic [7:0] DELAY_CYC = 8'(`TCD_DELAY_CYC);

	// Weight of one LSB in 16-bit units for a resolution code
	function automatic logic [15:0] lsb_step(input tcd_pkg::tcd_res_t r);
		case (r)
			tcd_pkg::TCD_RES_10: lsb_step = 16'h0040;
			tcd_pkg::TCD_RES_12: lsb_step = 16'h0010;
			tcd_pkg::TCD_RES_14: lsb_step = 16'h0004;
			default: lsb_step = 16'h0001;
		endcase
	endfunction

	// Keeps positions at and above the selected LSB
	function automatic logic [15:0] res_mask(input tcd_pkg::tcd_res_t r);
		res_mask = ~(lsb_step(r) - 16'h0001);
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] cnt_sync;
	logic [3:0] fault_sync;
	logic [1:0] res_sync;
	logic [2:0] ctl_sync;
	logic [1:0] cnt_prev;
	logic hold_n;
	logic upper_en_n;
	logic lower_en_n;

	// One bank for all pins; enables and hold idle high as if pulled up
	tcd_sync #(
		.W(11),
		.INIT(11'h007)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.d({count_up, count_down, fault_pins, res_sel_hi, res_sel_lo,
			hold_output_n, upper_byte_enable_n, lower_byte_enable_n}),
		.q({cnt_sync, fault_sync, res_sync, ctl_sync})
	);

	assign hold_n = ctl_sync[2];
	assign upper_en_n = ctl_sync[1];
	assign lower_en_n = ctl_sync[0];

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic track_en;
	logic force_fault;
	logic aw_got;
	logic w_got;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;

	// ----------------------------------------
	// Converter state
	// ----------------------------------------
	tcd_pkg::tcd_res_t res;
	tcd_pkg::tcd_state_t state;
	logic [7:0] pulse_cnt;
	logic [15:0] angle;
	logic [15:0] next_angle;
	logic [15:0] out_data;
	logic [15:0] held_word;
	logic up_evt;
	logic dn_evt;
	logic [16:0] err_abs;
	logic [16:0] err_limit;
	logic err_big;

	// ----------------------------------------
	// Angle counter
	// ----------------------------------------
	// Rising edges of the settled VCO lines give one count each
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_prev <= 2'h0;
		end else if (ce) begin
			cnt_prev <= cnt_sync;
		end
	end

	assign up_evt = cnt_sync[1] & ~cnt_prev[1] & track_en;
	assign dn_evt = cnt_sync[0] & ~cnt_prev[0] & track_en;

	// Step first, trim second: a count on the strobe's last cycle is kept
	assign next_angle = (up_evt == dn_evt) ? angle :
		(up_evt ? angle + lsb_step(res) : angle - lsb_step(res));

	// Counter runs regardless of hold, so no count is lost
	// 16-bit arithmetic wraps both ways at full scale
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			angle <= 16'h0000;
		end else if (ce) begin
			if (state == tcd_pkg::TCD_PULSE && pulse_cnt == STROBE_CYC - 8'h01) begin
				angle <= next_angle & res_mask(tcd_pkg::tcd_res_t'(res_sync));
			end else begin
				angle <= next_angle;
			end
		end
	end

	// ----------------------------------------
	// Update strobe sequencer
	// ----------------------------------------
	// A strobe starts whenever the counter differs from the published word;
	// counts arriving mid-pulse are caught by the next strobe
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= tcd_pkg::TCD_IDLE;
			pulse_cnt <= 8'h00;
		end else if (ce) begin
			case (state)
				tcd_pkg::TCD_IDLE: begin
					pulse_cnt <= 8'h00;
					if (angle != out_data) begin
						state <= tcd_pkg::TCD_PULSE;
					end
				end
				tcd_pkg::TCD_PULSE: begin
					pulse_cnt <= pulse_cnt + 8'h01;
					if (pulse_cnt == STROBE_CYC - 8'h01) begin
						state <= tcd_pkg::TCD_IDLE;
					end
				end
				default: state <= tcd_pkg::TCD_IDLE;
			endcase
		end
	end

	// Strobe is high exactly while the sequencer is in its pulse state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			update_strobe <= 1'b0;
		end else if (ce) begin
			if (state == tcd_pkg::TCD_IDLE && angle != out_data) begin
				update_strobe <= 1'b1;
			end else if (state == tcd_pkg::TCD_PULSE && pulse_cnt == STROBE_CYC - 8'h01) begin
				update_strobe <= 1'b0;
			end
		end
	end

	// Internal data follows the counter only after the leading-edge delay,
	// so a hold arriving with the strobe never sees a moving word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_data <= 16'h0000;
		end else if (ce) begin
			if (state == tcd_pkg::TCD_PULSE && pulse_cnt == DELAY_CYC - 8'h01) begin
				out_data <= angle & res_mask(res);
			end
		end
	end

	// ----------------------------------------
	// Resolution select
	// ----------------------------------------
	// Captured on the strobe trailing edge to avoid racing the counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			res <= tcd_pkg::tcd_res_t'(`TCD_RES_RESET);
		end else if (ce) begin
			if (state == tcd_pkg::TCD_PULSE && pulse_cnt == STROBE_CYC - 8'h01) begin
				res <= tcd_pkg::tcd_res_t'(res_sync);
			end
		end
	end

	// ----------------------------------------
	// Hold latch
	// ----------------------------------------
	// Transparent only while strobe low and hold released; a hold during
	// a pulse keeps the word from before the pulse, never a half-moved one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			held_word <= 16'h0000;
		end else if (ce) begin
			if (!update_strobe && hold_n) begin
				held_word <= out_data & res_mask(res);
			end
		end
	end

	// ----------------------------------------
	// Byte lanes
	// ----------------------------------------
	// Data from flip-flops; enable follows the settled pin each cycle
	assign upper_lane.data = held_word[15:8];
	assign upper_lane.oe = ~upper_en_n;
	assign lower_lane.data = held_word[7:0];
	assign lower_lane.oe = ~lower_en_n;

	// ----------------------------------------
	// Fault flag
	// ----------------------------------------
	// Threshold scales with the resolution in force
	assign err_abs = tracking_error[16] ? 17'(-tracking_error) : 17'(tracking_error);
	assign err_limit = 17'(`TCD_FAULT_LSBS * {1'b0, lsb_step(res)});
	assign err_big = err_abs > err_limit;

	// Recomputed every cycle, so it clears once the causes go away
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_n <= 1'b1;
		end else if (ce) begin
			fault_n <= ~(err_big | (|fault_sync) | force_fault);
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
	assign s_axi_wready = ~w_got & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign wr_fire = aw_got & w_got & ~s_axi_bvalid;

	// Address and data are taken in either order and held until both are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_got <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_got <= 1'b0;
			end
		end
	end

	// Only the control word is writable; other offsets answer with an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			track_en <= 1'(`TCD_CTRL_RESET >> `TCD_CTRL_TRACK_BIT);
			force_fault <= 1'(`TCD_CTRL_RESET >> `TCD_CTRL_FORCE_BIT);
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (ce) begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == `TCD_OFF_CTRL) ? 2'h0 : 2'h2;
				if (aw_addr == `TCD_OFF_CTRL && w_strb[0]) begin
					track_en <= w_data[`TCD_CTRL_TRACK_BIT];
					force_fault <= w_data[`TCD_CTRL_FORCE_BIT];
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Reads answer the cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case (s_axi_araddr)
					`TCD_OFF_CTRL: s_axi_rdata <= {30'h0, force_fault, track_en};
					`TCD_OFF_STATUS: s_axi_rdata <= {27'h0, update_strobe, ~hold_n,
						res, fault_n};
					`TCD_OFF_ANGLE: s_axi_rdata <= {16'h0, angle};
					`TCD_OFF_OUTWORD: s_axi_rdata <= {16'h0, held_word};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // tcd_top

//--- tcd_top_checker.sv
// Assertions on the converter port pins and the write answer of the register bus.
// Assumes ce held high; bound into tcd_top at the foot of this file.
`timescale 1ns/1ps
module tcd_top_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic signed [16:0] tracking_error,
	input wire tcd_pkg::tcd_fault_t fault_pins,
	input wire logic hold_output_n,
	input wire logic upper_byte_enable_n,
	input wire logic lower_byte_enable_n,
	input wire logic update_strobe,
	input wire logic fault_n,
	input wire tcd_pkg::tcd_lane_t upper_lane,
	input wire tcd_pkg::tcd_lane_t lower_lane,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp
);
	// ----------
	// Helpers
	// ----------
	logic [7:0] hi_cnt;

	// Strobe length; a counter because 100 cycles is too long to unroll
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hi_cnt <= 8'h00;
		end else begin
			hi_cnt <= update_strobe ? hi_cnt + 8'h01 : 8'h00;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ----------
	// Assertions
	// ----------
	// Error above 65 LSBs of the coarsest mode trips the flag in every mode
	fault_err_a: assert property (tracking_error > 17'sh01040 |-> ##[1:2] !fault_n)
		else $error("fault flag missed a large error");
	fault_pin_a: assert property ((fault_pins != 4'h0) [*8] |-> !fault_n)
		else $error("fault flag missed a fault pin");
	strobe_len_a: assert property ($fell(update_strobe) |-> hi_cnt == 8'h64)
		else $error("update strobe width wrong");
	upper_on_a: assert property ((!upper_byte_enable_n) [*8] |-> upper_lane.oe)
		else $error("upper byte not driven");
	upper_off_a: assert property (upper_byte_enable_n [*8] |-> !upper_lane.oe)
		else $error("upper byte driven while disabled");
	lower_oe_a: assert property ($stable(lower_byte_enable_n) [*8] |->
		lower_lane.oe == !lower_byte_enable_n)
		else $error("lower byte enable not followed");
	hold_freeze_a: assert property ((!hold_output_n) [*8] |->
		$stable(upper_lane.data) && $stable(lower_lane.data))
		else $error("held word moved");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");

	cover property ($fell(update_strobe));
	cover property (!fault_n);
	cover property (!hold_output_n && update_strobe);
endmodule // tcd_top_checker

bind tcd_top tcd_top_checker i_tcd_top_checker (.aclk(aclk), .aresetn(aresetn),
	.tracking_error(tracking_error), .fault_pins(fault_pins), .hold_output_n(hold_output_n),
	.upper_byte_enable_n(upper_byte_enable_n), .lower_byte_enable_n(lower_byte_enable_n),
	.update_strobe(update_strobe), .fault_n(fault_n), .upper_lane(upper_lane),
	.lower_lane(lower_lane), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp));

//--- tcd_host_model.sv
// Host bus model: inhibits the converter, reads upper then lower byte, releases.
// Assumes start is pulsed for one cycle and done is awaited before the next start.
`timescale 1ns/1ps
module tcd_host_model (
	input wire logic aclk,
	input wire logic start,
	input wire logic [15:0] dwell,
	input wire tcd_pkg::tcd_lane_t upper_lane,
	input wire tcd_pkg::tcd_lane_t lower_lane,
	output logic hold_output_n,
	output logic upper_byte_enable_n,
	output logic lower_byte_enable_n,
	output logic [15:0] word,
	output logic done
);
	wire logic [7:0] up_bus;
	wire logic [7:0] lo_bus;

	// Released lanes float, so a late or missing drive is never read as data
	assign up_bus = upper_lane.oe ? upper_lane.data : 8'hZZ;
	assign lo_bus = lower_lane.oe ? lower_lane.data : 8'hZZ;

	// Idle bus: nothing inhibited or enabled
	initial begin
		hold_output_n = 1'h1;
		upper_byte_enable_n = 1'h1;
		lower_byte_enable_n = 1'h1;
		word = 16'h0000;
		done = 1'h0;
	end

	// One transfer; dwell is at least 0.5 us so the held word has settled
	always @(posedge aclk) begin
		if (start) begin
			done <= 1'h0;
			hold_output_n <= 1'h0;
			repeat (dwell) @(posedge aclk);
			upper_byte_enable_n <= 1'h0;
			repeat (40) @(posedge aclk);
			word[15:8] <= up_bus;
			upper_byte_enable_n <= 1'h1;
			lower_byte_enable_n <= 1'h0;
			repeat (40) @(posedge aclk);
			word[7:0] <= lo_bus;
			lower_byte_enable_n <= 1'h1;
			hold_output_n <= 1'h1;
			done <= 1'h1;
		end
	end
endmodule // tcd_host_model

//--- tcd_top_tb.sv
// Bench for the converter port: register bus tasks, host reads, count and fault cases.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/1ps
`include "tcd_params.svh"
module tcd_top_tb;
	logic aclk;
	logic aresetn = 1'h0;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic cnt_up = 1'h0, cnt_dn = 1'h0, start = 1'h0;
	logic sel_hi = 1'h1, sel_lo = 1'h1;
	logic signed [16:0] terr = 17'h0;
	tcd_pkg::tcd_fault_t fpins = 4'h0;
	logic [15:0] dwell = 16'h0080;
	logic awready, wready, bvalid, arready, rvalid, strobe, fault_n, hold_n, ub_n, lb_n, done;
	logic [1:0] bresp, rresp;
	logic [1:0] cur = 2'h3;
	logic [31:0] rdata;
	logic [15:0] hword, exp_a;
	tcd_pkg::tcd_lane_t up_l, lo_l;
	logic [1:0] codes [4] = '{2'h2, 2'h1, 2'h0, 2'h3}; // 14-bit first
	logic signed [16:0] errs [5] = '{17'h00041, 17'h00042, 17'h1FFBE, 17'h01041, 17'h00000};
	logic [4:0] fexp = 5'h11;
	int num_errors = 0;
	int num_checks = 0;

	tcd_top i_tcd_top (.aclk(aclk), .aresetn(aresetn), .ce(1'h1), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .count_up(cnt_up),
		.count_down(cnt_dn), .tracking_error(terr), .fault_pins(fpins), .res_sel_hi(sel_hi),
		.res_sel_lo(sel_lo), .hold_output_n(hold_n), .upper_byte_enable_n(ub_n),
		.lower_byte_enable_n(lb_n), .update_strobe(strobe), .fault_n(fault_n),
		.upper_lane(up_l), .lower_lane(lo_l));

	tcd_host_model i_tcd_host_model (.aclk(aclk), .start(start), .dwell(dwell),
		.upper_lane(up_l), .lower_lane(lo_l), .hold_output_n(hold_n),
		.upper_byte_enable_n(ub_n), .lower_byte_enable_n(lb_n), .word(hword), .done(done));

	// 250 MHz clock
	initial begin
		aclk = 1'h0;
		forever #2 aclk = ~aclk;
	end

	// ----------
	// Tasks
	// ----------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic tmo(input logic bad);
		if (bad) begin
			num_errors++;
			print_verdict();
		end
	endtask

	// Address and data offered together; each dropped once taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic ta, tw;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		ta = 1'h0;
		tw = 1'h0;
		n = 0;
		while (!(ta && tw) && n < 500) begin
			@(negedge aclk);
			ta = ta || awready;
			tw = tw || wready;
			@(posedge aclk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
			n++;
		end
		do begin
			@(negedge aclk);
			n++;
		end while (!bvalid && n < 500);
		check(bresp, er);
		@(posedge aclk);
		bready <= 1'h1;
		@(posedge aclk);
		bready <= 1'h0;
		tmo(n >= 500);
	endtask

	task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] msk);
		int n;
		araddr <= a;
		arvalid <= 1'h1;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (!arready && n < 500);
		@(posedge aclk);
		arvalid <= 1'h0;
		do begin
			@(negedge aclk);
			n++;
		end while (!rvalid && n < 500);
		check(rdata & msk, exp);
		check(rresp, 2'h0);
		@(posedge aclk);
		rready <= 1'h1;
		@(posedge aclk);
		rready <= 1'h0;
		tmo(n >= 500);
	endtask

	// Waits until the strobe has stayed low for 30 cycles
	task automatic quiet();
		int n, q;
		n = 0;
		q = 0;
		while (q < 30 && n < 2000) begin
			@(negedge aclk);
			q = strobe ? 0 : q + 1;
			n++;
		end
		@(posedge aclk);
		tmo(n >= 2000);
	endtask

	task automatic step(input logic up);
		if (up)
			cnt_up <= 1'h1;
		else
			cnt_dn <= 1'h1;
		repeat (6) @(posedge aclk);
		cnt_up <= 1'h0;
		cnt_dn <= 1'h0;
		repeat (6) @(posedge aclk);
	endtask

	task automatic host_go(input logic [15:0] dw);
		dwell <= dw;
		start <= 1'h1;
		@(posedge aclk);
		start <= 1'h0;
	endtask

	task automatic host_end();
		int n;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (!done && n < 3000);
		@(posedge aclk);
		tmo(n >= 3000);
	endtask

	// One LSB in 16-bit units for a resolution code
	function automatic logic [15:0] lsb(input logic [1:0] c);
		return 16'h0001 << (3'h6 - {c, 1'h0});
	endfunction

	// ----------
	// Sequence
	// ----------
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rd_reg(`TCD_OFF_CTRL, 32'h1, 32'hFFFFFFFF);
		rd_reg(`TCD_OFF_STATUS, 32'h7, 32'h1F);
		wr(`TCD_OFF_STATUS, 32'h0, 2'h2);
		wr(`TCD_OFF_CTRL, 32'h3, 2'h0);
		rd_reg(`TCD_OFF_CTRL, 32'h3, 32'hFFFFFFFF);
		rd_reg(`TCD_OFF_STATUS, 32'h0, 32'h1);
		wr(`TCD_OFF_CTRL, 32'h1, 2'h0);
		$display("Test registers done");
		// Each mode in turn; the count lands at the old step, masking at the new
		exp_a = 16'h0000;
		foreach (codes[i]) begin
			{sel_hi, sel_lo} <= codes[i];
			repeat (6) @(posedge aclk);
			step(1'h0);
			exp_a = (exp_a - lsb(cur)) & ~(lsb(codes[i]) - 16'h1);
			cur = codes[i];
			quiet();
			rd_reg(`TCD_OFF_STATUS, {29'h0, cur, 1'h1}, 32'h7);
			host_go(16'h0080);
			host_end();
			check(hword, exp_a);
			rd_reg(`TCD_OFF_ANGLE, exp_a, 32'hFFFF);
		end
		$display("Test resolution done");
		// Count while the host holds the word
		host_go(16'h0400);
		quiet();
		step(1'h0);
		quiet();
		rd_reg(`TCD_OFF_ANGLE, exp_a - 16'h1, 32'hFFFF);
		rd_reg(`TCD_OFF_STATUS, 32'hF, 32'hF);
		host_end();
		check(hword, exp_a);
		exp_a = exp_a - 16'h1;
		quiet();
		host_go(16'h0080);
		host_end();
		check(hword, exp_a);
		rd_reg(`TCD_OFF_OUTWORD, {16'h0, exp_a}, 32'hFFFF);
		step(1'h1);
		quiet();
		rd_reg(`TCD_OFF_ANGLE, exp_a + 16'h1, 32'hFFFF);
		$display("Test hold done");
		foreach (errs[i]) begin
			terr <= errs[i];
			repeat (2) @(posedge aclk);
			rd_reg(`TCD_OFF_STATUS, {31'h0, fexp[i]}, 32'h1);
		end
		for (int i = 0; i < 4; i++) begin
			fpins <= 4'h1 << i;
			repeat (8) @(posedge aclk);
			rd_reg(`TCD_OFF_STATUS, 32'h0, 32'h1);
		end
		fpins <= 4'h0;
		repeat (8) @(posedge aclk);
		rd_reg(`TCD_OFF_STATUS, 32'h1, 32'h1);
		$display("Test fault done");
		print_verdict();
	end
endmodule // tcd_top_tb
